// ---- irqf_consts.svh ----
// register offsets, field positions and reset values of the request flag block
`ifndef IRQF_CONSTS_SVH
`define IRQF_CONSTS_SVH

// ----------------------------------------------------------------------------
// register indices and byte addresses (axi4-lite, one word each)
// ----------------------------------------------------------------------------
// the printed flag offset is odd, so every offset is a word index; byte address = index * 4
`define IRQF_EXT_FLAGS_INDEX 16'hfff9
`define IRQF_PERIPH_FLAGS_INDEX 16'hfffa
`define IRQF_SERIAL_CTL_INDEX 16'hfffb
`define IRQF_EVENT_CTL_INDEX 16'hfffc
`define IRQF_EXT_FLAGS_ADDR {`IRQF_EXT_FLAGS_INDEX, 2'b00}
`define IRQF_PERIPH_FLAGS_ADDR {`IRQF_PERIPH_FLAGS_INDEX, 2'b00}
`define IRQF_SERIAL_CTL_ADDR {`IRQF_SERIAL_CTL_INDEX, 2'b00}
`define IRQF_EVENT_CTL_ADDR {`IRQF_EVENT_CTL_INDEX, 2'b00}

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define IRQF_DT_BIT 7
`define IRQF_AD_BIT 6
`define IRQF_S1_BIT 4
`define IRQF_TXD_BIT 2
`define IRQF_OD_BIT 0
`define IRQF_DT_ENABLE_BIT 0

// ----------------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------------
`define IRQF_FLAGS_RESET 8'h00
`define IRQF_PERIPH_MASK 8'hd0
`define IRQF_SERIAL_MASK 8'h05
`define IRQF_SERIAL_FIXED 8'hf8
`define IRQF_SERIAL_RESET 8'h00
`define IRQF_TB1_MAX 8'hff
`define IRQF_TB1_ZERO 8'h00

`endif

// ---- irqf_pkg.sv ----
// types shared by the request flag block
package irqf_pkg;
    typedef logic [7:0] irqf_byte_t;
    typedef enum logic [1:0] {
        IRQF_RD_IDLE,
        IRQF_RD_RESP
    } irqf_rd_e;
endpackage

// ---- irqf_edge_det.sv ----
// edge detector for the eight external interrupt pins
`timescale 1ns/10ps
`default_nettype none
module irqf_edge_det
    import irqf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_pins,
    input wire logic [7:0] i_rising,
    output logic [7:0] o_edge
);
    logic [7:0] prev;
    logic [7:0] next_prev;

    always_comb begin
        next_prev = i_pins;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            // track the pins through reset so no false edge follows release
            prev <= i_pins;
        end else begin
            prev <= next_prev;
        end
    end

    // per pin: 1 selects rising edge, 0 falling edge
    assign o_edge = (i_rising & i_pins & ~prev) | (~i_rising & ~i_pins & prev);
endmodule
`default_nettype wire

// ---- irqf_top.sv ----
// interrupt request flags and serial pin control behind an axi4-lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "irqf_consts.svh"
module irqf_top
    import irqf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [17:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [17:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [7:0] i_timer_b1_count,
    input wire logic i_conversion_done,
    input wire logic i_converter_busy_bit,
    input wire logic i_sleep_exec,
    input wire logic i_direct_transfer_made,
    input wire logic i_serial1_transfer_done,
    input wire logic [7:0] i_ext_pins,
    input wire logic [7:0] i_ext_edge_rising,
    input wire logic i_txd,
    input wire logic i_port_out,
    input wire logic i_port_oe,
    input wire logic i_sclk_out,
    output logic o_txd_pin_out,
    output logic o_txd_pin_oe,
    output logic o_sclk_pin_out,
    output logic o_sclk_pin_oe,
    output logic [7:0] o_ext_flags,
    output logic [7:0] o_periph_flags
);
    // ------------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------------
    irqf_byte_t ext_flags, next_ext_flags;
    irqf_byte_t periph_flags, next_periph_flags;
    irqf_byte_t serial_ctl, next_serial_ctl;
    logic direct_transfer_enable, next_direct_transfer_enable;
    logic [7:0] tb1_prev, next_tb1_prev;
    logic [7:0] ext_edge;

    // write channel state
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [17:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;

    // read channel state
    irqf_rd_e rd_state, next_rd_state;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;

    function automatic logic addr_known(input logic [17:0] a);
        return a == `IRQF_EXT_FLAGS_ADDR || a == `IRQF_PERIPH_FLAGS_ADDR ||
               a == `IRQF_SERIAL_CTL_ADDR || a == `IRQF_EVENT_CTL_ADDR;
    endfunction

    // a zero written to a flag position clears it; set wins over clear
    function automatic irqf_byte_t flag_update(input irqf_byte_t cur,
                                               input irqf_byte_t set,
                                               input irqf_byte_t clr);
        return (cur & ~clr) | set;
    endfunction

    irqf_edge_det u_edge (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pins(i_ext_pins),
        .i_rising(i_ext_edge_rising),
        .o_edge(ext_edge)
    );

    // ------------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------------
    logic wr_fire;
    logic wr_lane0;
    irqf_byte_t wr_byte;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_lane0 = wr_fire && w_strb[0];
    assign wr_byte = w_data[7:0];
    assign o_awready = !aw_held && !bvalid;
    assign o_wready = !w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        if (i_awvalid && o_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = i_awaddr;
        end
        if (i_wvalid && o_wready) begin
            next_w_held = 1'b1;
            next_w_data = i_wdata;
            next_w_strb = i_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = addr_known(aw_addr) ? 2'b00 : 2'b10;
        end else if (bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // flags and control
    // ------------------------------------------------------------------------
    irqf_byte_t ext_set, ext_clr, per_set, per_clr;
    always_comb begin
        next_tb1_prev = i_timer_b1_count;
        ext_set = ext_edge;
        per_set = 8'h00;
        per_set[`IRQF_DT_BIT] = i_sleep_exec && direct_transfer_enable
                               && i_direct_transfer_made;
        per_set[`IRQF_AD_BIT] = i_conversion_done && !i_converter_busy_bit;
        per_set[`IRQF_S1_BIT] = i_serial1_transfer_done;
        ext_clr = 8'h00;
        per_clr = 8'h00;
        if (wr_lane0 && aw_addr == `IRQF_EXT_FLAGS_ADDR) begin
            ext_clr = ~wr_byte & ext_flags;
        end
        if (wr_lane0 && aw_addr == `IRQF_PERIPH_FLAGS_ADDR) begin
            // only a flag that reads one can be cleared
            per_clr = ~wr_byte & periph_flags & `IRQF_PERIPH_MASK;
        end
        next_ext_flags = flag_update(ext_flags, ext_set, ext_clr);
        next_periph_flags = flag_update(periph_flags, per_set, per_clr);
        next_serial_ctl = serial_ctl;
        if (wr_lane0 && aw_addr == `IRQF_SERIAL_CTL_ADDR) begin
            next_serial_ctl = wr_byte & `IRQF_SERIAL_MASK;
        end
        next_direct_transfer_enable = direct_transfer_enable;
        if (wr_lane0 && aw_addr == `IRQF_EVENT_CTL_ADDR) begin
            next_direct_transfer_enable = wr_byte[`IRQF_DT_ENABLE_BIT];
        end
    end

    // timer b1 flag lives in bit 1 of the event register read image
    logic tb1_flag, next_tb1_flag;
    always_comb begin
        next_tb1_flag = tb1_flag;
        if (wr_lane0 && aw_addr == `IRQF_EVENT_CTL_ADDR && !wr_byte[1]) begin
            next_tb1_flag = 1'b0;
        end
        if (tb1_prev == `IRQF_TB1_MAX && i_timer_b1_count == `IRQF_TB1_ZERO) begin
            next_tb1_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------------
    assign o_arready = rd_state == IRQF_RD_IDLE;
    always_comb begin
        next_rd_state = rd_state;
        next_rdata = rdata;
        next_rresp = rresp;
        case (rd_state)
            IRQF_RD_IDLE: begin
                if (i_arvalid) begin
                    next_rd_state = IRQF_RD_RESP;
                    next_rresp = addr_known(i_araddr) ? 2'b00 : 2'b10;
                    next_rdata = 32'h0000_0000;
                    case (i_araddr)
                        `IRQF_EXT_FLAGS_ADDR: next_rdata[7:0] = ext_flags;
                        `IRQF_PERIPH_FLAGS_ADDR: next_rdata[7:0] = periph_flags;
                        `IRQF_SERIAL_CTL_ADDR:
                            next_rdata[7:0] = serial_ctl | `IRQF_SERIAL_FIXED;
                        `IRQF_EVENT_CTL_ADDR:
                            next_rdata[7:0] = {6'b00_0000, tb1_flag, direct_transfer_enable};
                        default: next_rdata = 32'h0000_0000;
                    endcase
                end
            end
            IRQF_RD_RESP: begin
                if (i_rready) begin
                    next_rd_state = IRQF_RD_IDLE;
                end
            end
            default: next_rd_state = IRQF_RD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 18'h0_0000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            rd_state <= IRQF_RD_IDLE;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
            ext_flags <= `IRQF_FLAGS_RESET;
            periph_flags <= `IRQF_FLAGS_RESET;
            serial_ctl <= `IRQF_SERIAL_RESET;
            direct_transfer_enable <= 1'b0;
            tb1_prev <= i_timer_b1_count;
            tb1_flag <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rd_state <= next_rd_state;
            rdata <= next_rdata;
            rresp <= next_rresp;
            ext_flags <= next_ext_flags;
            periph_flags <= next_periph_flags;
            serial_ctl <= next_serial_ctl;
            direct_transfer_enable <= next_direct_transfer_enable;
            tb1_prev <= next_tb1_prev;
            tb1_flag <= next_tb1_flag;
        end
    end

    assign o_bvalid = bvalid;
    assign o_bresp = bresp;
    assign o_rvalid = rd_state == IRQF_RD_RESP;
    assign o_rdata = rdata;
    assign o_rresp = rresp;
    assign o_ext_flags = ext_flags;
    assign o_periph_flags = periph_flags;

    // ------------------------------------------------------------------------
    // shared pins
    // ------------------------------------------------------------------------
    assign o_txd_pin_out = serial_ctl[`IRQF_TXD_BIT] ? i_txd : i_port_out;
    assign o_txd_pin_oe = serial_ctl[`IRQF_TXD_BIT] ? 1'b1 : i_port_oe;
    // open drain drives only the low level and floats for a one
    assign o_sclk_pin_out = i_sclk_out;
    assign o_sclk_pin_oe = serial_ctl[`IRQF_OD_BIT] ? !i_sclk_out : 1'b1;
endmodule
`default_nettype wire

// ---- irqf_chk.sv ----
// concurrent checks on the request flag block ports
`timescale 1ns/10ps
`default_nettype none
module irqf_chk
    import irqf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic o_bvalid,
    input wire logic i_conversion_done,
    input wire logic i_converter_busy_bit,
    input wire logic i_sleep_exec,
    input wire logic i_direct_transfer_made,
    input wire logic i_serial1_transfer_done,
    input wire logic [7:0] i_ext_pins,
    input wire logic [7:0] i_ext_edge_rising,
    input wire logic i_txd,
    input wire logic i_port_out,
    input wire logic i_sclk_out,
    input wire logic o_txd_pin_out,
    input wire logic o_sclk_pin_out,
    input wire logic o_sclk_pin_oe,
    input wire logic [7:0] o_ext_flags,
    input wire logic [7:0] o_periph_flags
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_AD_SET: assert property (i_conversion_done && !i_converter_busy_bit |=> o_periph_flags[6])
        else $error("converter flag not set");
    AST_AD_CAUSE: assert property ($rose(o_periph_flags[6]) |->
        $past(i_conversion_done) && !$past(i_converter_busy_bit)) else $error("converter flag set early");
    AST_DT_CAUSE: assert property ($rose(o_periph_flags[7]) |->
        $past(i_sleep_exec) && $past(i_direct_transfer_made)) else $error("transfer flag set early");
    AST_S1_SET: assert property (i_serial1_transfer_done |=> o_periph_flags[4])
        else $error("serial flag not set");
    // one-cycle resets would otherwise look like a software clear
    AST_CLR: assert property (!$past(i_rst) && (|(~o_ext_flags & $past(o_ext_flags)) ||
        |(~o_periph_flags & $past(o_periph_flags))) |-> $rose(o_bvalid)) else $error("flag lost");
    AST_TXD: assert property (o_txd_pin_out == i_txd || o_txd_pin_out == i_port_out)
        else $error("txd pin source wrong");
    AST_SCLK: assert property (o_sclk_pin_out == i_sclk_out && (i_sclk_out || o_sclk_pin_oe))
        else $error("clock pin drive wrong");
    for (genvar n = 0; n < 8; n++) begin : g_pin
        AST_EXT_SET: assert property ($changed(i_ext_pins[n]) &&
            i_ext_pins[n] == i_ext_edge_rising[n] |-> ##[1:4] o_ext_flags[n]) else $error("pin flag");
    end
endmodule
bind irqf_top irqf_chk u_chk (.*);
`default_nettype wire

// ---- tb_irqf_top.sv ----
// self-checking bench for the request flag block
`timescale 1ns/10ps
`default_nettype none
`include "irqf_consts.svh"
module tb_irqf_top
    import irqf_pkg::*;
;
    localparam logic [17:0] a_ext = `IRQF_EXT_FLAGS_ADDR;
    localparam logic [17:0] a_per = `IRQF_PERIPH_FLAGS_ADDR;
    localparam logic [17:0] a_ctl = `IRQF_SERIAL_CTL_ADDR;
    localparam logic [17:0] a_evt = `IRQF_EVENT_CTL_ADDR;
    logic i_clk = 1'h0;
    logic i_rst = 1'h1;
    logic [17:0] i_awaddr = 18'h0_0000, i_araddr = 18'h0_0000;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [3:0] i_wstrb = 4'h1;
    logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
    logic [7:0] i_timer_b1_count = 8'hfe;
    logic [7:0] i_ext_pins = 8'haa, i_ext_edge_rising = 8'h55;
    logic [4:0] evs = 5'h00;
    logic [3:0] pv = 4'h0;
    logic i_conversion_done, i_converter_busy_bit, i_sleep_exec;
    logic i_direct_transfer_made, i_serial1_transfer_done;
    logic i_txd, i_port_out, i_port_oe, i_sclk_out;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, ka, kw, kb;
    logic o_txd_pin_out, o_txd_pin_oe, o_sclk_pin_out, o_sclk_pin_oe;
    logic [1:0] o_bresp, o_rresp, r;
    logic [31:0] o_rdata, q;
    logic [7:0] o_ext_flags, o_periph_flags;
    int err_total = 0, comparisons = 0;
    assign {i_conversion_done, i_converter_busy_bit, i_sleep_exec} = evs[4:2];
    assign {i_direct_transfer_made, i_serial1_transfer_done} = evs[1:0];
    assign {i_txd, i_port_out, i_port_oe, i_sclk_out} = pv;
    irqf_top u_dut (.*);
    initial forever #2.5 i_clk = ~i_clk;
    // ----
    // tasks
    // ----
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic hang();
        err_total++;
        $display("unexpected at %0t: handshake timeout", $time);
        report_and_stop();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // readies are sampled mid-cycle, where they have long settled
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge i_clk);
        i_awaddr <= a;
        i_wdata <= 32'(d);
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(negedge i_clk);
            ka = o_awready;
            kw = o_wready;
            kb = o_bvalid;
            r = o_bresp;
            @(posedge i_clk);
            if (ka) i_awvalid <= 1'h0;
            if (kw) i_wvalid <= 1'h0;
            if (kb) begin
                i_bready <= 1'h0;
                chk(32'(r), 32'(er));
                return;
            end
        end
        hang();
    endtask
    task automatic rc(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
        @(posedge i_clk);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        for (int n = 0; n < 40; n++) begin
            @(negedge i_clk);
            ka = o_arready;
            kb = o_rvalid;
            q = o_rdata;
            r = o_rresp;
            @(posedge i_clk);
            if (ka) i_arvalid <= 1'h0;
            if (kb) begin
                i_rready <= 1'h0;
                chk(q, e);
                chk(32'(r), 32'(er));
                return;
            end
        end
        hang();
    endtask
    task automatic ev(input logic [4:0] v);
        @(posedge i_clk);
        evs <= v;
        @(posedge i_clk);
        evs <= 5'h00;
    endtask
    task automatic pc(input logic [3:0] v, input logic [3:0] e);
        @(posedge i_clk);
        pv <= v;
        @(negedge i_clk);
        chk(32'({o_txd_pin_out, o_txd_pin_oe, o_sclk_pin_out, o_sclk_pin_oe}), 32'(e));
    endtask
    // ----
    // sequence
    // ----
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'h0;
        rc(a_ext, 32'h0000_0000);
        rc(a_per, 32'h0000_0000);
        rc(a_ctl, 32'h0000_00f8);
        rc(a_evt, 32'h0000_0000);
        rc(18'h0_0000, 32'h0000_0000, 2'h2);
        wr(18'h0_0000, 8'hff, 2'h2);
        rc(a_per, 32'h0000_0000);
        @(posedge i_clk);
        i_timer_b1_count <= 8'hff;
        @(posedge i_clk);
        i_timer_b1_count <= 8'h00;
        rc(a_evt, 32'h0000_0002);
        wr(a_evt, 8'hff);
        rc(a_evt, 32'h0000_0003);
        wr(a_evt, 8'h01);
        rc(a_evt, 32'h0000_0001);
        ev(5'h18);
        ev(5'h04);
        ev(5'h02);
        rc(a_per, 32'h0000_0000);
        ev(5'h10);
        ev(5'h06);
        ev(5'h01);
        rc(a_per, 32'h0000_00d0);
        @(negedge i_clk);
        chk(32'(o_periph_flags), 32'h0000_00d0);
        wr(a_per, 8'hff);
        rc(a_per, 32'h0000_00d0);
        wr(a_per, 8'hbf);
        rc(a_per, 32'h0000_0090);
        wr(a_per, 8'h7f);
        wr(a_evt, 8'h00);
        ev(5'h06);
        rc(a_per, 32'h0000_0010);
        wr(a_per, 8'h00);
        rc(a_per, 32'h0000_0000);
        @(posedge i_clk);
        i_ext_pins <= 8'h55;
        repeat (4) @(posedge i_clk);
        rc(a_ext, 32'h0000_00ff);
        @(negedge i_clk);
        chk(32'(o_ext_flags), 32'h0000_00ff);
        wr(a_ext, 8'h0f);
        rc(a_ext, 32'h0000_000f);
        wr(a_ext, 8'h00);
        i_ext_pins <= 8'haa;
        repeat (4) @(posedge i_clk);
        rc(a_ext, 32'h0000_0000);
        wr(a_ctl, 8'h05);
        rc(a_ctl, 32'h0000_00fd);
        pc(4'h9, 4'he);
        pc(4'h6, 4'h5);
        wr(a_ctl, 8'h00);
        pc(4'hb, 4'h7);
        pc(4'h4, 4'h9);
        report_and_stop();
    end
endmodule
`default_nettype wire
